// ===== cdrb_register_bank.sv
// Functional notes
// RQ1: address 0x55 frame writes control word
// RQ2: control word fields at fixed bit positions
// RQ3: resistor select bit picks external resistor
// RQ4: host sets resistor select with enable
// RQ5: output stays off unless enable bit
// RQ6: slew enable steps output, else direct
// RQ7: range codes 101, 110, 111 select ranges
// RQ8: 12-bit variant ignores low four bits
// RQ9: 16-bit variant uses all data bits
// RQ10: address 0x56 targets reset register bit0
// RQ11: reset bit restores power-on state fully; code clears pin synchronisers and edge detectors on rst only
// RQ12: status read-only, fault, slew, overtemp bits
// RQ13: fault flag follows output-stage monitor
// RQ14: slew flag high while output slewing
// RQ15: overtemp flag follows temperature sensor
// RQ16: address 0x01 frame writes data register
// RQ17: read address picks register, shifted next
// RQ18: all registers zero after reset
// RQ19: chain mode ripples bits past 24
// RQ20: reset bit self-clears, other ranges unsupported
// RQ21: control readback returns last written word
`timescale 1ns/10ps
module cdrb_register_bank #(
    parameter int RES = 16,
    parameter int SLEW_REF_HZ = cdrb_pkg::CLK_HZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link pins
    input wire logic sclkPin,
    input wire logic serialInputPin,
    input wire logic latchPin,
    output logic serialOutputO,
    output logic serialOutputOe,
    // analog monitors
    input wire logic outputFaultPin,
    input wire logic overTempPin,
    // analog controls
    output logic currentOutEnable,
    output logic extResistorSelect,
    output logic [2:0] rangeSel,
    output logic rangeSupported,
    output logic [RES-1:0] dacCode,
    output logic slewActive
);

    initial begin
        if (RES != 12 && RES != 16) begin
            $error("cdrb_register_bank: RES must be 12 or 16");
        end
    end

    localparam int NSYNC = 5;
    localparam int S_SCLK = 0;
    localparam int S_SERIAL_INPUT = 1;
    localparam int S_LATCH = 2;
    localparam int S_FAULT = 3;
    localparam int S_OTEMP = 4;

    logic [NSYNC-1:0] pinIn;
    logic [NSYNC-1:0] syncA_ff, syncB_ff;
    logic sclkPrev_ff, latchPrev_ff;
    logic sclkRise, sclkFall, latchRise;
    logic effRst;

    logic [23:0] shift_ff, nxt_shift;
    logic [cdrb_pkg::EDGE_CNT_BITS-1:0] edgeCnt_ff, nxt_edgeCnt;
    logic sdo_ff, nxt_sdo;
    logic readPend_ff, nxt_readPend;
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [15:0] data_ff, nxt_data;
    logic swRst_ff, nxt_swRst;

    logic [7:0] frameAddr;
    logic [15:0] frameData;
    logic frameOk;
    logic [15:0] statusWord;
    logic [15:0] readWord;
    logic [15:0] slewCode;
    logic slewBusy;

    assign pinIn = {overTempPin, outputFaultPin, latchPin, serialInputPin, sclkPin};

    // two-stage synchronisers for every pin input
    always_ff @(posedge clk) begin
        if (rst) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
            sclkPrev_ff <= 1'b0;
            latchPrev_ff <= 1'b0;
        end else begin
            syncA_ff <= pinIn;
            syncB_ff <= syncA_ff;
            sclkPrev_ff <= syncB_ff[S_SCLK];
            latchPrev_ff <= syncB_ff[S_LATCH];
        end
    end

    assign sclkRise = syncB_ff[S_SCLK] && !sclkPrev_ff;
    assign sclkFall = !syncB_ff[S_SCLK] && sclkPrev_ff;
    assign latchRise = syncB_ff[S_LATCH] && !latchPrev_ff;
    assign effRst = rst || swRst_ff; // RQ11

    assign frameAddr = shift_ff[cdrb_pkg::ADDR_MSB:cdrb_pkg::ADDR_LSB];
    assign frameData = shift_ff[15:0];

    // exactly 24 edges standalone; in a chain our word is the last 24
    assign frameOk = (edgeCnt_ff == cdrb_pkg::EDGE_CNT_BITS'(cdrb_pkg::FRAME_BITS)) ||
        (ctrl_ff[cdrb_pkg::CTRL_CHAIN_EN_BIT] &&
        edgeCnt_ff >= cdrb_pkg::EDGE_CNT_BITS'(cdrb_pkg::FRAME_BITS)); // RQ19

    always_comb begin
        statusWord = '0;
        statusWord[cdrb_pkg::ST_FAULT_BIT] = syncB_ff[S_FAULT]; // RQ12 RQ13
        statusWord[cdrb_pkg::ST_SLEW_BIT] = slewBusy; // RQ14
        statusWord[cdrb_pkg::ST_OTEMP_BIT] = syncB_ff[S_OTEMP]; // RQ15
        case (frameData[1:0]) // RQ17
            cdrb_pkg::RD_STATUS: readWord = statusWord;
            cdrb_pkg::RD_DATA: readWord = data_ff;
            cdrb_pkg::RD_CTRL: readWord = ctrl_ff; // RQ21
            default: readWord = 16'h0000;
        endcase
    end

    // frame capture, register writes and readback shifting
    always_comb begin
        nxt_shift = shift_ff;
        nxt_edgeCnt = edgeCnt_ff;
        nxt_sdo = sdo_ff;
        nxt_readPend = readPend_ff;
        nxt_ctrl = ctrl_ff;
        nxt_data = data_ff;
        nxt_swRst = 1'b0; // RQ20
        if (latchRise) begin
            nxt_edgeCnt = '0;
            nxt_readPend = 1'b0;
            if (frameOk) begin
                case (frameAddr)
                    cdrb_pkg::ADDR_CTRL: begin
                        nxt_ctrl = frameData & cdrb_pkg::CTRL_WRITE_MASK; // RQ1 RQ2
                    end
                    cdrb_pkg::ADDR_DATA: begin
                        if (RES == 12) begin
                            nxt_data = frameData & cdrb_pkg::DATA_MASK_12; // RQ8
                        end else begin
                            nxt_data = frameData; // RQ9 RQ16
                        end
                    end
                    cdrb_pkg::ADDR_RESET: begin
                        nxt_swRst = frameData[cdrb_pkg::RESET_BIT]; // RQ10 RQ11
                    end
                    cdrb_pkg::ADDR_READ: begin
                        nxt_shift = {8'h00, readWord}; // RQ17
                        nxt_sdo = 1'b0;
                        nxt_readPend = 1'b1;
                    end
                    default: begin
                        nxt_shift = shift_ff;
                    end
                endcase
            end
        end else if (sclkRise) begin
            nxt_shift = {shift_ff[22:0], syncB_ff[S_SERIAL_INPUT]};
            if (edgeCnt_ff != '1) begin
                nxt_edgeCnt = edgeCnt_ff + cdrb_pkg::EDGE_CNT_BITS'(1);
            end
        end else if (sclkFall) begin
            nxt_sdo = shift_ff[23]; // RQ19
        end
    end

    always_ff @(posedge clk) begin
        if (effRst) begin
            shift_ff <= cdrb_pkg::SHIFT_RESET; // RQ18
            edgeCnt_ff <= '0;
            sdo_ff <= 1'b0;
            readPend_ff <= 1'b0;
            ctrl_ff <= cdrb_pkg::CTRL_RESET;
            data_ff <= cdrb_pkg::DATA_RESET;
            swRst_ff <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            edgeCnt_ff <= nxt_edgeCnt;
            sdo_ff <= nxt_sdo;
            readPend_ff <= nxt_readPend;
            ctrl_ff <= nxt_ctrl;
            data_ff <= nxt_data;
            swRst_ff <= nxt_swRst;
        end
    end

    cdrb_slew_engine #(
        .REF_HZ(SLEW_REF_HZ)
    ) u_slew (
        .clk(clk),
        .rst(effRst),
        .enable(ctrl_ff[cdrb_pkg::CTRL_SLEW_EN_BIT]), // RQ6
        .rateSel(ctrl_ff[cdrb_pkg::CTRL_RATE_LSB +: 4]),
        .stepSel(ctrl_ff[cdrb_pkg::CTRL_STEP_LSB +: 3]),
        .target(data_ff),
        .code(slewCode),
        .active(slewBusy)
    );

    // serial output is driven during a readback or while chaining
    assign serialOutputO = sdo_ff;
    assign serialOutputOe = readPend_ff || ctrl_ff[cdrb_pkg::CTRL_CHAIN_EN_BIT]; // RQ17 RQ19

    assign rangeSel = ctrl_ff[cdrb_pkg::CTRL_RANGE_LSB +: 3];
    assign rangeSupported = (rangeSel == cdrb_pkg::RANGE_4_20) ||
        (rangeSel == cdrb_pkg::RANGE_0_20) || (rangeSel == cdrb_pkg::RANGE_0_24); // RQ7 RQ20
    assign currentOutEnable = ctrl_ff[cdrb_pkg::CTRL_OUT_EN_BIT] && rangeSupported; // RQ5
    assign extResistorSelect = ctrl_ff[cdrb_pkg::CTRL_EXT_RES_BIT]; // RQ3
    assign dacCode = slewCode[15 -: RES]; // RQ8 RQ9
    assign slewActive = slewBusy; // RQ14

    a_ctrl_write: assert property (@(posedge clk) disable iff (effRst) // RQ1
        (latchRise && frameOk && frameAddr == cdrb_pkg::ADDR_CTRL) |=>
        ctrl_ff == ($past(frameData) & cdrb_pkg::CTRL_WRITE_MASK))
        else $error("control word not written");

    a_data_write: assert property (@(posedge clk) disable iff (effRst) // RQ16
        (latchRise && frameOk && frameAddr == cdrb_pkg::ADDR_DATA) |=>
        data_ff[15:4] == $past(frameData[15:4]))
        else $error("data word not written");

    a_soft_reset: assert property (@(posedge clk) disable iff (rst) // RQ11
        (latchRise && frameOk && frameAddr == cdrb_pkg::ADDR_RESET && frameData[0]) |=>
        ##1 (ctrl_ff == 16'h0000 && data_ff == 16'h0000 && !swRst_ff))
        else $error("soft reset did not clear registers");

    a_out_gate: assert property (@(posedge clk) disable iff (effRst) // RQ5
        currentOutEnable |-> (ctrl_ff[cdrb_pkg::CTRL_OUT_EN_BIT] && rangeSel[2]))
        else $error("output on without enable");

    a_low_bits: assert property (@(posedge clk) disable iff (effRst) // RQ8
        (RES == 12) |-> data_ff[3:0] == 4'h0)
        else $error("low data bits kept in 12-bit mode");

    a_slew_direct: assert property (@(posedge clk) disable iff (effRst) // RQ6
        (!ctrl_ff[cdrb_pkg::CTRL_SLEW_EN_BIT])[*2] |-> slewCode == $past(data_ff))
        else $error("output not direct without slew");

    a_slew_flag: assert property (@(posedge clk) disable iff (effRst) // RQ14
        (ctrl_ff[cdrb_pkg::CTRL_SLEW_EN_BIT] && $stable(ctrl_ff) && $stable(data_ff)) |->
        (slewActive == (slewCode != data_ff)))
        else $error("slew flag without slewing");

    a_fault_flag: assert property (@(posedge clk) disable iff (rst) // RQ13
        (!$past(rst) && !$past(rst, 2)) |->
        statusWord[cdrb_pkg::ST_FAULT_BIT] == $past(outputFaultPin, 2))
        else $error("fault flag missed");

    a_otemp_flag: assert property (@(posedge clk) disable iff (rst) // RQ15
        (!$past(rst) && !$past(rst, 2)) |->
        statusWord[cdrb_pkg::ST_OTEMP_BIT] == $past(overTempPin, 2))
        else $error("overtemp flag missed");

    a_read_oe: assert property (@(posedge clk) disable iff (effRst) // RQ17
        (latchRise && frameOk && frameAddr == cdrb_pkg::ADDR_READ) |=>
        (serialOutputOe && shift_ff[15:0] == $past(readWord)))
        else $error("readback not loaded");

    a_chain_oe: assert property (@(posedge clk) disable iff (effRst) // RQ19
        ctrl_ff[cdrb_pkg::CTRL_CHAIN_EN_BIT] |-> serialOutputOe)
        else $error("serial output off in chain mode");

    a_ctrl_fields: assert property (@(posedge clk) disable iff (effRst) // RQ2
        (ctrl_ff & ~cdrb_pkg::CTRL_WRITE_MASK) == 16'h0000)
        else $error("control bits 15 and 14 not zero");

    a_range_decode: assert property (@(posedge clk) disable iff (effRst) // RQ7 RQ20
        rangeSupported == (rangeSel[2] && (rangeSel[1] || rangeSel[0])))
        else $error("range code decoded wrongly");

    a_reset_ignore: assert property (@(posedge clk) disable iff (effRst) // RQ10
        (latchRise && frameOk && frameAddr == cdrb_pkg::ADDR_RESET &&
        !frameData[cdrb_pkg::RESET_BIT]) |=> !swRst_ff)
        else $error("reset without reset bit");

    a_reset_pulse: assert property (@(posedge clk) disable iff (rst) // RQ20
        swRst_ff |=> !swRst_ff)
        else $error("reset bit did not self-clear");

    a_bad_frame: assert property (@(posedge clk) disable iff (effRst) // RQ1
        (latchRise && !frameOk) |=> ($stable(ctrl_ff) && $stable(data_ff)))
        else $error("bad frame changed a register");

    a_status_zero: assert property (@(posedge clk) disable iff (effRst) // RQ12
        statusWord[15:3] == 13'h0000)
        else $error("reserved status bits set");

    a_data_full: assert property (@(posedge clk) disable iff (effRst) // RQ9
        (RES == 16 && latchRise && frameOk && frameAddr == cdrb_pkg::ADDR_DATA) |=>
        data_ff == $past(frameData))
        else $error("full data word not written");

    a_reset_zero: assert property (@(posedge clk) // RQ18
        $past(effRst) |-> (ctrl_ff == cdrb_pkg::CTRL_RESET && data_ff == cdrb_pkg::DATA_RESET &&
        shift_ff == cdrb_pkg::SHIFT_RESET && !readPend_ff))
        else $error("registers not cleared by reset");

endmodule

// ===== cdrb_pkg.sv
package cdrb_pkg;

    // frame layout
    localparam int FRAME_BITS = 24;
    localparam int ADDR_MSB = 23;
    localparam int ADDR_LSB = 16;
    localparam int EDGE_CNT_BITS = 6;

    // address byte values
    localparam logic [7:0] ADDR_NOP = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h01;
    localparam logic [7:0] ADDR_READ = 8'h02;
    localparam logic [7:0] ADDR_CTRL = 8'h55;
    localparam logic [7:0] ADDR_RESET = 8'h56;

    // read address select codes
    localparam logic [1:0] RD_STATUS = 2'h0;
    localparam logic [1:0] RD_DATA = 2'h1;
    localparam logic [1:0] RD_CTRL = 2'h2;

    // control word fields
    localparam int CTRL_EXT_RES_BIT = 13;
    localparam int CTRL_OUT_EN_BIT = 12;
    localparam int CTRL_RATE_LSB = 8;
    localparam int CTRL_STEP_LSB = 5;
    localparam int CTRL_SLEW_EN_BIT = 4;
    localparam int CTRL_CHAIN_EN_BIT = 3;
    localparam int CTRL_RANGE_LSB = 0;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'h3FFF;

    // range codes
    localparam logic [2:0] RANGE_4_20 = 3'h5;
    localparam logic [2:0] RANGE_0_20 = 3'h6;
    localparam logic [2:0] RANGE_0_24 = 3'h7;

    // reset register and status word
    localparam int RESET_BIT = 0;
    localparam int ST_FAULT_BIT = 2;
    localparam int ST_SLEW_BIT = 1;
    localparam int ST_OTEMP_BIT = 0;

    // reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [23:0] SHIFT_RESET = 24'h000000;

    // low data bits dropped by the 12-bit variant
    localparam logic [15:0] DATA_MASK_12 = 16'hFFF0;

    // slew timing
    localparam int CLK_HZ = 200000000;
    localparam int SLEW_STEP_MAX = 5;
    localparam int SLEW_UPDATE_HZ [16] = '{257730, 198410, 152440, 131580, 115740, 69440,
        37590, 25770, 20160, 16030, 10290, 8280, 6900, 5530, 4240, 3300};

endpackage

// ===== cdrb_slew_engine.sv
`timescale 1ns/10ps
module cdrb_slew_engine #(
    parameter int REF_HZ = cdrb_pkg::CLK_HZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // settings
    input wire logic enable,
    input wire logic [3:0] rateSel,
    input wire logic [2:0] stepSel,
    input wire logic [15:0] target,
    // result
    output logic [15:0] code,
    output logic active
);

    initial begin
        if (REF_HZ / cdrb_pkg::SLEW_UPDATE_HZ[15] >= 2 ** 24 ||
            REF_HZ < cdrb_pkg::SLEW_UPDATE_HZ[0]) begin
            $error("cdrb_slew_engine: REF_HZ out of range");
        end
    end

    logic [23:0] periodTab [16];
    logic [23:0] tickCnt_ff, nxt_tickCnt;
    logic [15:0] code_ff, nxt_code;
    logic active_ff, nxt_active;
    logic [16:0] stepAmt;
    logic [16:0] gap;
    logic tick;

    // update interval per rate code, fixed at elaboration
    for (genvar g = 0; g < 16; g++) begin : g_period
        assign periodTab[g] = 24'(REF_HZ / cdrb_pkg::SLEW_UPDATE_HZ[g] - 1);
    end

    always_comb begin
        stepAmt = 17'h00001 << ((stepSel > 3'(cdrb_pkg::SLEW_STEP_MAX)) ?
            3'(cdrb_pkg::SLEW_STEP_MAX) : stepSel);
        tick = (tickCnt_ff >= periodTab[rateSel]);
        nxt_tickCnt = tick ? 24'h000000 : tickCnt_ff + 24'h000001;
        nxt_code = code_ff;
        if (target >= code_ff) begin
            gap = {1'b0, target} - {1'b0, code_ff};
        end else begin
            gap = {1'b0, code_ff} - {1'b0, target};
        end
        if (!enable) begin
            nxt_code = target;
            nxt_tickCnt = 24'h000000;
        end else if (tick && gap != 17'h00000) begin
            if (gap <= stepAmt) begin
                nxt_code = target;
            end else if (target > code_ff) begin
                nxt_code = code_ff + stepAmt[15:0];
            end else begin
                nxt_code = code_ff - stepAmt[15:0];
            end
        end
        nxt_active = enable && (nxt_code != target);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tickCnt_ff <= 24'h000000;
            code_ff <= cdrb_pkg::DATA_RESET;
            active_ff <= 1'b0;
        end else begin
            tickCnt_ff <= nxt_tickCnt;
            code_ff <= nxt_code;
            active_ff <= nxt_active;
        end
    end

    assign code = code_ff;
    assign active = active_ff;

endmodule

// ===== cdrb_host_model.sv
`timescale 1ns/10ps
module cdrb_host_model (
    // bench side
    input wire logic start,
    input wire logic [23:0] frame,
    input wire logic [5:0] nBits,
    output logic busy,
    output logic [23:0] readWord,
    // serial pins
    input wire logic serial_output,
    input wire logic sdoOe,
    output logic sclk,
    output logic sdi,
    output logic latch
);
    initial begin
        busy = 1'b0;
        readWord = 24'h000000;
        sclk = 1'b0;
        sdi = 1'b0;
        latch = 1'b0;
    end

    // link clock stands still between frames; released serial out reads inverted
    always @(posedge start) begin
        busy = 1'b1;
        for (int i = 0; i < nBits; i++) begin
            sclk = 1'b0;
            sdi = frame[23 - i];
            #32;
            readWord = {readWord[22:0], sdoOe ? serial_output : ~serial_output};
            sclk = 1'b1;
            #32;
        end
        sclk = 1'b0;
        sdi = ~sdi;
        #32;
        latch = 1'b1;
        #64;
        latch = 1'b0;
        #64;
        busy = 1'b0;
    end
endmodule

// ===== current_dac_register_bank_tb.sv
`timescale 1ns/10ps
module current_dac_register_bank_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [23:0] frame = 24'h000000;
    logic [5:0] nBits = 6'h18;
    logic faultPin = 1'b0;
    logic otPin = 1'b0;
    logic busy, sclk, sdi, latch, sdoO, sdoOe;
    logic output_enable_bit, extRes, rangeOk, slewAct;
    logic [23:0] readWord;
    logic [2:0] rangeSel;
    logic [15:0] code;
    logic [11:0] code12;
    logic [15:0] w, d, v;
    int err_count = 0;
    int cmp_count = 0;

    always #2.5 clk = ~clk;

    cdrb_host_model u_host (.start(start), .frame(frame), .nBits(nBits), .busy(busy),
        .readWord(readWord), .serial_output(sdoO), .sdoOe(sdoOe), .sclk(sclk), .sdi(sdi), .latch(latch));

    cdrb_register_bank #(.RES(16), .SLEW_REF_HZ(4000000)) u_dut (.clk(clk), .rst(rst),
        .sclkPin(sclk), .serialInputPin(sdi), .latchPin(latch), .serialOutputO(sdoO),
        .serialOutputOe(sdoOe), .outputFaultPin(faultPin), .overTempPin(otPin),
        .currentOutEnable(output_enable_bit), .extResistorSelect(extRes), .rangeSel(rangeSel),
        .rangeSupported(rangeOk), .dacCode(code), .slewActive(slewAct));

    // second variant shares the serial pins; only its code is watched
    cdrb_register_bank #(.RES(12), .SLEW_REF_HZ(4000000)) u_dut12 (.clk(clk), .rst(rst),
        .sclkPin(sclk), .serialInputPin(sdi), .latchPin(latch), .serialOutputO(),
        .serialOutputOe(), .outputFaultPin(faultPin), .overTempPin(otPin),
        .currentOutEnable(), .extResistorSelect(), .rangeSel(), .rangeSupported(),
        .dacCode(code12), .slewActive());

    function automatic logic expEn(input logic [15:0] cw);
        return cw[12] && (cw[2:0] >= 3'h5);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [23:0] f, input logic [5:0] n);
        @(posedge clk);
        frame <= f;
        nBits <= n;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int k = 0; k < 4000 && busy; k++)
            @(posedge clk);
        repeat (8) @(posedge clk);
    endtask

    task automatic rd(input logic [1:0] sel, output logic [15:0] val);
        send({cdrb_pkg::ADDR_READ, 14'h0000, sel}, 6'h18);
        chk({15'h0000, sdoOe}, 16'h0001);
        send(24'h000000, 6'h18);
        val = readWord[15:0];
        chk({8'h00, readWord[23:16]}, 16'h0000);
        chk({15'h0000, sdoOe}, 16'h0000);
    endtask

    task automatic results();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #300000;
        err_count++;
        results();
    end

    initial begin
        void'($urandom(6630));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({12'h000, output_enable_bit, slewAct, sdoOe, rangeOk}, 16'h0000);
        chk(code, 16'h0000);
        rd(cdrb_pkg::RD_CTRL, v);
        chk(v, cdrb_pkg::CTRL_RESET);
        for (int r = 0; r < 8; r++) begin
            w = (16'($urandom()) & 16'hEFE0) | 16'h1000 | 16'(r);
            send({cdrb_pkg::ADDR_CTRL, w}, 6'h18);
            chk({13'h0000, rangeSel}, 16'(r));
            chk({13'h0000, extRes, output_enable_bit, rangeOk}, {13'h0000, w[13], expEn(w), r >= 5});
            rd(cdrb_pkg::RD_CTRL, v);
            chk(v, w & cdrb_pkg::CTRL_WRITE_MASK);
        end
        send({cdrb_pkg::ADDR_CTRL, 16'h0006}, 6'h18);
        chk({15'h0000, output_enable_bit}, 16'h0000);
        send({cdrb_pkg::ADDR_CTRL, 16'h1007}, 6'h18);
        repeat (4) begin
            d = 16'($urandom());
            send({cdrb_pkg::ADDR_DATA, d}, 6'h18);
            chk(code, d);
            chk({4'h0, code12}, {4'h0, d[15:4]});
            rd(cdrb_pkg::RD_DATA, v);
            chk(v, d);
        end
        send({cdrb_pkg::ADDR_DATA, ~d}, 6'h17);
        chk(code, d);
        send({8'h33, ~d}, 6'h18);
        chk(code, d);
        send({cdrb_pkg::ADDR_RESET, 16'hFFFE}, 6'h18);
        chk(code, d);
        for (int s = 0; s < 4; s++) begin
            faultPin <= s[1];
            otPin <= s[0];
            rd(cdrb_pkg::RD_STATUS, v);
            chk(v, {13'h0000, s[1], 1'b0, s[0]});
        end
        send({cdrb_pkg::ADDR_DATA, 16'h0000}, 6'h18);
        send({cdrb_pkg::ADDR_CTRL, 16'h10B7}, 6'h18);
        send({cdrb_pkg::ADDR_DATA, 16'h4000}, 6'h18);
        chk({15'h0000, slewAct}, 16'h0001);
        rd(cdrb_pkg::RD_STATUS, v);
        chk(v, 16'h0007);
        for (int k = 0; k < 20000 && slewAct; k++)
            @(posedge clk);
        chk({15'h0000, slewAct}, 16'h0000);
        chk(code, 16'h4000);
        send({cdrb_pkg::ADDR_CTRL, 16'h0008}, 6'h18);
        chk({15'h0000, sdoOe}, 16'h0001);
        send({cdrb_pkg::ADDR_RESET, 16'h0001}, 6'h18);
        chk(readWord[15:0], 16'h0008);
        chk({8'h00, readWord[23:16]}, {8'h00, cdrb_pkg::ADDR_CTRL});
        chk({12'h000, output_enable_bit, slewAct, sdoOe, rangeOk}, 16'h0000);
        chk(code, 16'h0000);
        rd(cdrb_pkg::RD_CTRL, v);
        chk(v, 16'h0000);
        results();
    end
endmodule
